/* design/opp_pkg.sv */
// constants, types and state layout for the operator panel block
package opp_pkg;
  // clock rate and documented times
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned EDIT_TIMEOUT_MS = 5000;
  localparam int unsigned EDIT_TIMEOUT_CYC = CYC_PER_MS * EDIT_TIMEOUT_MS;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned BLINK_HALF_CYC = CYC_PER_MS * BLINK_HALF_MS;
  localparam int unsigned RPT_DELAY_MS = 500;
  localparam int unsigned RPT_DELAY_CYC = CYC_PER_MS * RPT_DELAY_MS;
  localparam int unsigned RPT_RATE_MS = 100;
  localparam int unsigned RPT_RATE_CYC = CYC_PER_MS * RPT_RATE_MS;
  localparam int TMR_W = 28;

  // apb register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MONSEL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FREF = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_LIMIT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PARAM = 8'h14;
  localparam int CTRL_LR_EN_BIT = 0;
  localparam logic CTRL_LR_EN_RST = 1'b1;

  // power-up monitor selection: one 3-bit digit per position, highest first
  localparam int MON_DIGITS = 5;
  localparam int MON_DIG_W = 3;
  localparam int MON_W = MON_DIGITS * MON_DIG_W;
  localparam logic [MON_W-1:0] MONSEL_RST = 15'h1000;
  typedef enum logic [MON_DIG_W-1:0] {
    OPP_MON_NONE = 3'h0, OPP_MON_CURR = 3'h1, OPP_MON_VOLT = 3'h2, OPP_MON_DCBUS = 3'h3,
    OPP_MON_TEMP = 3'h4, OPP_MON_PID = 3'h5, OPP_MON_AI1 = 3'h6, OPP_MON_AI2 = 3'h7
  } opp_mon_t;

  // edited values, limits and digit steps
  localparam int VAL_W = 16;
  localparam logic [VAL_W-1:0] UPPER_RST = 16'h1770;
  localparam logic [VAL_W-1:0] LOWER_RST = 16'h0000;
  localparam logic [VAL_W-1:0] FREF_RST = 16'h0000;
  localparam logic [3:0][VAL_W-1:0] STEP_TBL = {16'h03e8, 16'h0064, 16'h000a, 16'h0001};
  localparam logic [1:0] DIGIT_LAST = 2'h3;

  // parameter groups
  localparam int GRP_W = 5;
  localparam logic [GRP_W-1:0] GROUP_LAST = 5'h18;
  localparam logic [GRP_W-1:0] AUTOTUNE_GRP = 5'h11;
  localparam int PIDX_W = 7;
  localparam logic [PIDX_W-1:0] PIDX_LAST = 7'h63;

  // menu screens, one-hot
  typedef enum logic [4:0] {
    OPP_MN_MON = 5'b00001,
    OPP_MN_FREF = 5'b00010,
    OPP_MN_GRP = 5'b00100,
    OPP_MN_LIST = 5'b01000,
    OPP_MN_EDIT = 5'b10000
  } opp_menu_t;

  typedef struct packed {
    logic up; logic down; logic shift; logic enter; logic dsp; logic locrem;
  } opp_keys_t;

  typedef struct packed {
    logic fault; logic running; logic stopping; logic run_cmd;
    logic reverse; logic seq_ext; logic ref_ext;
  } opp_drive_t;

  typedef struct packed {
    logic fault; logic forward_lamp; logic reverse_lamp; logic run; logic seq; logic refsrc;
  } opp_lamps_t;

  typedef struct packed {
    opp_keys_t k1; opp_keys_t k2; opp_keys_t k3; opp_keys_t kp;
    opp_lamps_t lamps;
    logic [TMR_W-1:0] blink_cnt; logic blink;
    opp_menu_t menu; logic local_mode; logic fault_rst; logic autotune_vis;
    logic [VAL_W-1:0] fref; logic [VAL_W-1:0] edit;
    logic [VAL_W-1:0] upper; logic [VAL_W-1:0] lower;
    logic [1:0] digit; logic [TMR_W-1:0] to_cnt; logic [TMR_W-1:0] rpt_cnt;
    logic lr_en; logic [MON_W-1:0] monsel;
    logic [GRP_W-1:0] grp; logic [PIDX_W-1:0] pidx;
    logic par_we; logic [VAL_W-1:0] par_wdata;
    logic pready; logic pslverr; logic [31:0] prdata;
  } opp_state_t;
endpackage : opp_pkg

/* design/opp_panel.sv */
// operator panel: lamps, key navigation, reference and parameter editing, apb registers
`timescale 1ns/1ns
`default_nettype none

module opp_panel #(
  parameter int unsigned EDIT_TO_CYC = opp_pkg::EDIT_TIMEOUT_CYC,
  parameter int unsigned BLINK_CYC = opp_pkg::BLINK_HALF_CYC,
  parameter int unsigned RPT_DELAY = opp_pkg::RPT_DELAY_CYC,
  parameter int unsigned RPT_RATE = opp_pkg::RPT_RATE_CYC
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [opp_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // panel keys and drive status
  input wire opp_pkg::opp_keys_t KEYS,
  input wire opp_pkg::opp_drive_t DRIVE,
  input wire logic [opp_pkg::VAL_W-1:0] PAR_RDATA,
  // lamps and drive controls
  output opp_pkg::opp_lamps_t LAMPS,
  output logic LOCAL_MODE,
  output logic FAULT_RESET,
  output logic AUTOTUNE_VIS,
  output logic [opp_pkg::MON_W-1:0] MON_SEL,
  output logic [opp_pkg::VAL_W-1:0] FREF,
  output opp_pkg::opp_menu_t MENU,
  // parameter store port
  output logic PAR_WE,
  output logic [opp_pkg::GRP_W-1:0] PAR_GRP,
  output logic [opp_pkg::PIDX_W-1:0] PAR_IDX,
  output logic [opp_pkg::VAL_W-1:0] PAR_WDATA
);
  import opp_pkg::*;

  localparam logic [TMR_W-1:0] TO_LAST = TMR_W'(EDIT_TO_CYC - 1);
  localparam logic [TMR_W-1:0] BLINK_LAST = TMR_W'(BLINK_CYC - 1);
  localparam logic [TMR_W-1:0] RPT_LAST = TMR_W'(RPT_DELAY - 1);
  localparam logic [TMR_W-1:0] RPT_RELOAD = TMR_W'(RPT_DELAY - RPT_RATE);

  opp_state_t s_r;
  opp_state_t s_nxt;

  // group step with wrap, skipping the tuning group when it is hidden
  function automatic logic [GRP_W-1:0] grp_step(input logic [GRP_W-1:0] g, input logic up,
                                                input logic hide);
    logic [GRP_W-1:0] n;
    n = up ? ((g == GROUP_LAST) ? '0 : g + 1'b1) : ((g == '0) ? GROUP_LAST : g - 1'b1);
    if (hide && n == AUTOTUNE_GRP) begin
      n = up ? n + 1'b1 : n - 1'b1;
    end
    return n;
  endfunction

  logic step_up;
  logic step_dn;
  logic rpt_fire;
  logic hide_tune;
  logic stopped;
  logic [VAL_W-1:0] step;
  logic [VAL_W:0] sum_up;
  logic [VAL_W:0] lim_dn;
  logic [VAL_W-1:0] fref_up;
  logic [VAL_W-1:0] fref_dn;
  logic apb_acc;

  // shared helper terms for the state update
  always_comb begin
    rpt_fire = (s_r.k2.up | s_r.k2.down) && s_r.rpt_cnt == RPT_LAST;
    step_up = s_r.kp.up | (rpt_fire & s_r.k2.up);
    step_dn = s_r.kp.down | (rpt_fire & s_r.k2.down);
    hide_tune = DRIVE.running | DRIVE.fault;
    stopped = ~DRIVE.running & ~DRIVE.stopping;
    step = STEP_TBL[s_r.digit];
    sum_up = {1'b0, s_r.edit} + {1'b0, step};
    lim_dn = {1'b0, s_r.lower} + {1'b0, step};
    // rollover at the limits keeps the reference inside its legal band
    fref_up = (sum_up > {1'b0, s_r.upper}) ? s_r.lower : sum_up[VAL_W-1:0];
    fref_dn = ({1'b0, s_r.edit} < lim_dn) ? s_r.upper : s_r.edit - step;
    apb_acc = PSEL & PENABLE & s_r.pready;
  end

  // next-state logic for the whole panel
  always_comb begin
    s_nxt = s_r;
    // keys are asynchronous pins: two flops, edge found past the second only
    s_nxt.k1 = KEYS;
    s_nxt.k2 = s_r.k1;
    s_nxt.k3 = s_r.k2;
    s_nxt.kp = s_r.k2 & ~s_r.k3;
    s_nxt.fault_rst = 1'b0;
    s_nxt.par_we = 1'b0;

    // one blink phase for every lamp, so flashing lamps stay in step
    if (s_r.blink_cnt == BLINK_LAST) begin
      s_nxt.blink_cnt = '0;
      s_nxt.blink = ~s_r.blink;
    end else begin
      s_nxt.blink_cnt = s_r.blink_cnt + 1'b1;
    end

    // lamps from drive state
    s_nxt.lamps.fault = DRIVE.fault;
    s_nxt.lamps.forward_lamp = DRIVE.reverse ? 1'b0 :
                      ((DRIVE.running & DRIVE.run_cmd) ? 1'b1 : s_r.blink);
    s_nxt.lamps.reverse_lamp = !DRIVE.reverse ? 1'b0 :
                      ((DRIVE.running & DRIVE.run_cmd) ? 1'b1 : s_r.blink);
    s_nxt.lamps.run = DRIVE.stopping ? s_r.blink : DRIVE.running;
    s_nxt.lamps.seq = DRIVE.seq_ext;
    s_nxt.lamps.refsrc = DRIVE.ref_ext;
    s_nxt.autotune_vis = ~hide_tune;

    // auto-repeat: first fire after the hold delay, then at the repeat rate
    if (!(s_r.k2.up | s_r.k2.down)) begin
      s_nxt.rpt_cnt = '0;
    end else if (rpt_fire) begin
      s_nxt.rpt_cnt = RPT_RELOAD;
    end else begin
      s_nxt.rpt_cnt = s_r.rpt_cnt + 1'b1;
    end

    // local/remote only toggles while stopped and when the key is enabled
    if (s_r.kp.locrem && s_r.lr_en && stopped) begin
      s_nxt.local_mode = ~s_r.local_mode;
    end

    // shift clears a fault from any screen
    if (s_r.kp.shift) begin
      s_nxt.fault_rst = 1'b1;
    end

    // menu screens
    case (s_r.menu)
      OPP_MN_MON: begin
        if (s_r.kp.dsp) begin
          s_nxt.menu = OPP_MN_GRP;
        end else if (s_r.kp.up | s_r.kp.down) begin
          s_nxt.menu = OPP_MN_FREF;
          s_nxt.edit = s_r.fref;
          s_nxt.digit = '0;
          s_nxt.to_cnt = '0;
        end
      end
      OPP_MN_FREF: begin
        s_nxt.to_cnt = s_r.to_cnt + 1'b1;
        if (s_r.kp.enter) begin
          s_nxt.fref = s_r.edit;
          s_nxt.menu = OPP_MN_MON;
        end else if (s_r.kp.dsp) begin
          s_nxt.menu = OPP_MN_MON;
        end else if (s_r.to_cnt == TO_LAST) begin
          s_nxt.menu = OPP_MN_MON;
        end else if (step_up | step_dn | s_r.kp.shift) begin
          // any edit activity restarts the confirmation window
          s_nxt.to_cnt = '0;
          if (step_up) begin
            s_nxt.edit = fref_up;
          end else if (step_dn) begin
            s_nxt.edit = fref_dn;
          end else begin
            s_nxt.digit = (s_r.digit == DIGIT_LAST) ? '0 : s_r.digit + 1'b1;
          end
        end
      end
      OPP_MN_GRP: begin
        if (s_r.kp.dsp) begin
          s_nxt.menu = OPP_MN_MON;
        end else if (s_r.kp.enter) begin
          s_nxt.menu = OPP_MN_LIST;
          s_nxt.pidx = '0;
        end else if (step_up | step_dn) begin
          s_nxt.grp = grp_step(s_r.grp, step_up, hide_tune);
        end else if (hide_tune && s_r.grp == AUTOTUNE_GRP) begin
          s_nxt.grp = grp_step(s_r.grp, 1'b1, 1'b1);
        end
      end
      OPP_MN_LIST: begin
        if (s_r.kp.dsp) begin
          s_nxt.menu = OPP_MN_GRP;
        end else if (s_r.kp.enter) begin
          s_nxt.menu = OPP_MN_EDIT;
          s_nxt.edit = PAR_RDATA;
          s_nxt.digit = '0;
        end else if (step_up) begin
          s_nxt.pidx = (s_r.pidx == PIDX_LAST) ? '0 : s_r.pidx + 1'b1;
        end else if (step_dn) begin
          s_nxt.pidx = (s_r.pidx == '0) ? PIDX_LAST : s_r.pidx - 1'b1;
        end
      end
      OPP_MN_EDIT: begin
        if (s_r.kp.dsp) begin
          s_nxt.menu = OPP_MN_LIST;
        end else if (s_r.kp.enter) begin
          s_nxt.par_we = 1'b1;
          s_nxt.par_wdata = s_r.edit;
        end else if (step_up) begin
          s_nxt.edit = sum_up[VAL_W-1:0];
        end else if (step_dn) begin
          s_nxt.edit = s_r.edit - step;
        end else if (s_r.kp.shift) begin
          s_nxt.digit = (s_r.digit == DIGIT_LAST) ? '0 : s_r.digit + 1'b1;
        end
      end
      default: begin
        s_nxt.menu = OPP_MN_MON;
      end
    endcase

    // apb: one wait state, write and read data land on the pready cycle
    s_nxt.pready = PSEL & PENABLE & ~s_r.pready;
    if (PSEL & PENABLE & ~s_r.pready) begin
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata = '0;
      if (PADDR == OFS_CTRL) begin
        s_nxt.prdata[CTRL_LR_EN_BIT] = s_r.lr_en;
      end else if (PADDR == OFS_MONSEL) begin
        s_nxt.prdata[MON_W-1:0] = s_r.monsel;
      end else if (PADDR == OFS_STATUS) begin
        s_nxt.prdata = {5'h00, s_r.pidx, s_r.grp, s_r.menu, s_r.digit,
                        s_r.autotune_vis, s_r.local_mode, s_r.lamps};
      end else if (PADDR == OFS_FREF) begin
        s_nxt.prdata = {s_r.edit, s_r.fref};
      end else if (PADDR == OFS_LIMIT) begin
        s_nxt.prdata = {s_r.upper, s_r.lower};
      end else if (PADDR == OFS_PARAM) begin
        s_nxt.prdata = {s_r.par_wdata, 16'h0000};
      end else begin
        s_nxt.pslverr = 1'b1;
      end
    end
    if (apb_acc && PWRITE) begin
      if (PADDR == OFS_CTRL) begin
        s_nxt.lr_en = PWDATA[CTRL_LR_EN_BIT];
      end else if (PADDR == OFS_MONSEL) begin
        s_nxt.monsel = PWDATA[MON_W-1:0];
      end else if (PADDR == OFS_LIMIT) begin
        s_nxt.lower = PWDATA[VAL_W-1:0];
        s_nxt.upper = PWDATA[31:VAL_W];
      end
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s_r <= '0;
      s_r.menu <= OPP_MN_MON;
      s_r.local_mode <= 1'b0;
      s_r.fref <= FREF_RST;
      s_r.upper <= UPPER_RST;
      s_r.lower <= LOWER_RST;
      s_r.lr_en <= CTRL_LR_EN_RST;
      s_r.monsel <= MONSEL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign PRDATA = s_r.prdata;
  assign PREADY = s_r.pready;
  assign PSLVERR = s_r.pslverr;
  assign LAMPS = s_r.lamps;
  assign LOCAL_MODE = s_r.local_mode;
  assign FAULT_RESET = s_r.fault_rst;
  assign AUTOTUNE_VIS = s_r.autotune_vis;
  assign MON_SEL = s_r.monsel;
  assign FREF = s_r.fref;
  assign MENU = s_r.menu;
  assign PAR_WE = s_r.par_we;
  assign PAR_GRP = s_r.grp;
  assign PAR_IDX = s_r.pidx;
  assign PAR_WDATA = s_r.par_wdata;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  property p_fault_lamp;
    DRIVE.fault |=> LAMPS.fault;
  endproperty
  a_fault_lamp: assert property (p_fault_lamp) else $error("fault lamp not lit");

  property p_fwd_dark;
    DRIVE.reverse |=> !LAMPS.forward_lamp;
  endproperty
  a_fwd_dark: assert property (p_fwd_dark) else $error("forward lamp lit in reverse");

  property p_rev_run;
    (DRIVE.reverse && DRIVE.running && DRIVE.run_cmd) |=> LAMPS.reverse_lamp;
  endproperty
  a_rev_run: assert property (p_rev_run) else $error("reverse lamp dark while running");

  property p_run_dark;
    (!DRIVE.running && !DRIVE.stopping) |=> !LAMPS.run;
  endproperty
  a_run_dark: assert property (p_run_dark) else $error("run lamp lit while stopped");

  property p_src_lamps;
    ##1 (LAMPS.seq == $past(DRIVE.seq_ext)) && (LAMPS.refsrc == $past(DRIVE.ref_ext));
  endproperty
  a_src_lamps: assert property (p_src_lamps) else $error("source lamps wrong");

  property p_remote_at_reset;
    disable iff (1'b0) RST |=> !LOCAL_MODE;
  endproperty
  a_remote_at_reset: assert property (p_remote_at_reset) else $error("not remote");

  property p_lr_running;
    (DRIVE.running && s_r.kp.locrem) |=> $stable(LOCAL_MODE);
  endproperty
  a_lr_running: assert property (p_lr_running) else $error("mode toggled running");

  property p_lr_disabled;
    (!s_r.lr_en) |=> $stable(LOCAL_MODE);
  endproperty
  a_lr_disabled: assert property (p_lr_disabled) else $error("disabled key toggled");

  property p_wrap_up;
    (MENU == OPP_MN_FREF && s_r.kp.up && !s_r.kp.enter && !s_r.kp.dsp && s_r.to_cnt != TO_LAST
     && sum_up > {1'b0, s_r.upper}) |=> s_r.edit == $past(s_r.lower);
  endproperty
  a_wrap_up: assert property (p_wrap_up) else $error("no wrap to lower limit");

  property p_timeout;
    (MENU == OPP_MN_FREF && s_r.to_cnt == TO_LAST && !s_r.kp.enter) |=> MENU == OPP_MN_MON
      && FREF == $past(FREF);
  endproperty
  a_timeout: assert property (p_timeout) else $error("edit timeout not taken");

  property p_store;
    (MENU == OPP_MN_EDIT && s_r.kp.enter && !s_r.kp.dsp) |=> PAR_WE ##1 !PAR_WE;
  endproperty
  a_store: assert property (p_store) else $error("store pulse missing");
endmodule // opp_panel
`default_nettype wire

/* dv/opp_operator_model.sv */
// operator and drive core model: presses keys and keeps the parameter store
`timescale 1ns/1ns
`default_nettype none
module opp_operator_model
  import opp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // key request from the bench
  input wire logic go,
  input wire opp_keys_t key,
  input wire logic [7:0] hold,
  output logic busy,
  output opp_keys_t keys,
  // parameter store port
  input wire logic [GRP_W-1:0] grp,
  input wire logic we,
  input wire logic [VAL_W-1:0] wdata,
  output logic [VAL_W-1:0] rdata
);
  logic [VAL_W-1:0] mem [0:31];
  logic [8:0] cnt;

  // a press holds the pin, then six low cycles so the panel sees a release
  always_ff @(posedge clk) begin
    if (rst) begin
      keys <= '0;
      cnt <= '0;
    end else if (go && cnt == 9'h0) begin
      keys <= key;
      cnt <= {1'b0, hold} + 9'h6;
    end else if (cnt != 9'h0) begin
      cnt <= cnt - 9'h1;
      if (cnt <= 9'h7) keys <= '0;
    end
  end
  assign busy = (cnt != 9'h0);

  // store seeded with group times 17 in reset, written on each store pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 32; i++) mem[i] <= 16'(i * 17);
    end else if (we) begin
      mem[grp] <= wdata;
    end
  end
  assign rdata = mem[grp];
endmodule // opp_operator_model
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the operator panel
`timescale 1ns/1ns
`default_nettype none
module tb;
  import opp_pkg::*;
  logic CLK_SYS = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [ADDR_W-1:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, r;
  logic PREADY, PSLVERR, e, LOCAL_MODE, FAULT_RESET, AUTOTUNE_VIS, PAR_WE, go = 1'b0, busy;
  opp_drive_t DRIVE = '0;
  opp_keys_t KEYS, kreq = '0;
  opp_lamps_t LAMPS;
  opp_menu_t MENU;
  logic [7:0] hold = 8'h2;
  logic [MON_W-1:0] MON_SEL;
  logic [VAL_W-1:0] FREF, PAR_WDATA, PAR_RDATA, wd;
  logic [GRP_W-1:0] PAR_GRP;
  logic [PIDX_W-1:0] PAR_IDX;
  int errors = 0, checks = 0, cyc = 0, nwe = 0, nfr = 0;
  localparam opp_keys_t K_UP = 6'h20, K_DN = 6'h10, K_SH = 6'h08, K_EN = 6'h04;
  localparam opp_keys_t K_DSP = 6'h02, K_LR = 6'h01;

  opp_panel #(.EDIT_TO_CYC(200), .BLINK_CYC(8), .RPT_DELAY(40), .RPT_RATE(10)) i_opp_panel (
    .CLK_SYS, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .KEYS, .DRIVE, .PAR_RDATA, .LAMPS, .LOCAL_MODE, .FAULT_RESET, .AUTOTUNE_VIS, .MON_SEL,
    .FREF, .MENU, .PAR_WE, .PAR_GRP, .PAR_IDX, .PAR_WDATA);
  opp_operator_model i_opp_operator_model (.clk(CLK_SYS), .rst(RST), .go(go), .key(kreq),
    .hold(hold), .busy(busy), .keys(KEYS), .grp(PAR_GRP), .we(PAR_WE), .wdata(PAR_WDATA),
    .rdata(PAR_RDATA));

  initial begin
    forever #10 CLK_SYS = ~CLK_SYS;
  end
  // one-cycle pulses are counted, values seen before the edge updates land
  always @(posedge CLK_SYS) begin
    cyc++;
    if (PAR_WE === 1'b1) begin
      nwe++;
      wd = PAR_WDATA;
    end
    if (FAULT_RESET === 1'b1) nfr++;
    if (cyc >= 20000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  // waits n edges, then settles at the falling edge for sampling
  task automatic nw(input int n);
    repeat (n) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
  endtask
  // apb master: request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    // answer taken at the very edge that samples pready high
    do @(posedge CLK_SYS); while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // settle so that register effects are visible to the caller
    @(negedge CLK_SYS);
  endtask
  task automatic press(input opp_keys_t k, input logic [7:0] h);
    @(posedge CLK_SYS);
    kreq <= k;
    hold <= h;
    go <= 1'b1;
    @(posedge CLK_SYS);
    go <= 1'b0;
    do @(negedge CLK_SYS); while (busy);
  endtask
  task automatic setdrv(input opp_drive_t d);
    @(posedge CLK_SYS);
    DRIVE <= d;
    nw(3);
  endtask
  // edited value sits in the upper half of the reference register
  task automatic chk_edit(input logic [15:0] x);
    apb(1'b0, OFS_FREF, '0);
    chk("edit", {16'h0, x}, {16'h0, r[31:16]});
  endtask

  task automatic t_reset();
    chk("local", 0, LOCAL_MODE);
    chk("menu", OPP_MN_MON, MENU);
    chk("monsel", MONSEL_RST, MON_SEL);
    apb(1'b0, OFS_CTRL, '0);
    chk("ctrl", 1, r);
    apb(1'b1, OFS_MONSEL, 32'h7d63);
    chk("monsel", 15'h7d63, MON_SEL);
    apb(1'b0, 8'h40, '0);
    chk("unmapped", 1, e);
  endtask
  task automatic t_lamps();
    int ones;
    setdrv(7'h6b);
    chk("lamps", 6'h37, LAMPS);
    setdrv(7'h2c);
    chk("lamps", 6'h0c, LAMPS);
    setdrv(7'h10);
    ones = 0;
    repeat (20) begin
      nw(0);
      ones += LAMPS.forward_lamp;
      chk("inphase", LAMPS.forward_lamp, LAMPS.run);
      chk("rev", 0, LAMPS.reverse_lamp);
      @(posedge CLK_SYS);
    end
    chk("flash", 1, ones > 0 && ones < 20);
  endtask
  task automatic t_locrem();
    setdrv('0);
    press(K_LR, 8'h2);
    chk("local", 1, LOCAL_MODE);
    setdrv(7'h20);
    press(K_LR, 8'h2);
    chk("local", 1, LOCAL_MODE);
    setdrv('0);
    apb(1'b1, OFS_CTRL, 32'h0);
    press(K_LR, 8'h2);
    chk("local", 1, LOCAL_MODE);
    apb(1'b1, OFS_CTRL, 32'h1);
    press(K_LR, 8'h2);
    chk("local", 0, LOCAL_MODE);
  endtask
  task automatic t_ref();
    press(K_UP, 8'h2);
    chk("menu", OPP_MN_FREF, MENU);
    press(K_DN, 8'h2);
    chk_edit(UPPER_RST);
    press(K_UP, 8'h2);
    chk_edit(LOWER_RST);
    press(K_DN, 8'h2);
    press(K_EN, 8'h2);
    chk("fref", UPPER_RST, FREF);
    chk("menu", OPP_MN_MON, MENU);
    press(K_UP, 8'h2);
    press(K_DN, 8'h50);
    apb(1'b0, OFS_FREF, '0);
    chk("repeat", 1, r[31:16] <= 16'h176d && r[31:16] >= 16'h176a);
    nw(230);
    chk("menu", OPP_MN_MON, MENU);
    chk("fref", UPPER_RST, FREF);
  endtask
  task automatic t_menu();
    press(K_DSP, 8'h2);
    chk("menu", OPP_MN_GRP, MENU);
    press(K_UP, 8'h2);
    chk("grp", 1, PAR_GRP);
    press(K_EN, 8'h2);
    chk("menu", OPP_MN_LIST, MENU);
    press(K_DN, 8'h2);
    chk("pidx", PIDX_LAST, PAR_IDX);
    press(K_EN, 8'h2);
    press(K_UP, 8'h2);
    press(K_EN, 8'h2);
    chk("store", 1, nwe);
    chk("wdata", 16'h0012, wd);
    chk("menu", OPP_MN_EDIT, MENU);
    press(K_DSP, 8'h2);
    chk("menu", OPP_MN_LIST, MENU);
    press(K_DSP, 8'h2);
    chk("menu", OPP_MN_GRP, MENU);
    press(K_DSP, 8'h2);
    chk("menu", OPP_MN_MON, MENU);
  endtask
  task automatic t_fault();
    setdrv(7'h40);
    chk("tune", 0, AUTOTUNE_VIS);
    setdrv(7'h00);
    chk("tune", 1, AUTOTUNE_VIS);
    setdrv(7'h20);
    chk("tune", 0, AUTOTUNE_VIS);
    press(K_SH, 8'h2);
    chk("freset", 1, nfr);
  endtask

  initial begin
    repeat (4) @(posedge CLK_SYS);
    RST <= 1'b0;
    nw(2);
    t_reset();
    t_lamps();
    t_locrem();
    t_ref();
    t_menu();
    t_fault();
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
